// *** shared/evrouter_consts.vh ***
/*
 constants for the event channel and user routing block: register
 offsets, field positions, reset values and path codes.
 assumes inclusion by bare name from a design file.
*/
`ifndef EVROUTER_CONSTS_VH
`define EVROUTER_CONSTS_VH
`define OFS_CHANNEL_SETUP   8'h04
`define OFS_USER_ROUTE      8'h08
`define OFS_CHANNEL_STATE   8'h0c
`define OFS_IRQ_EN_CLR      8'h10
`define OFS_IRQ_EN_SET      8'h14
`define OFS_IRQ_FLAG        8'h18
`define NUM_CHANNELS        8
`define NUM_USERS           14
`define USER_SEL_LIMIT      8'h0e
`define CHAN_CODE_LIMIT     8'h09
`define CHAN_SEL_LIMIT      8'h08
`define SOFT_EVT_BIT        8
`define PATH_LSB            24
`define PATH_SYNC           2'h0
`define PATH_RESYNC         2'h1
`define PATH_ASYNC          2'h2
`define USER_ROUTE_RESET    16'h0000
`define CHANNEL_STATE_RESET 32'h000f00ff
`define IRQ_EN_RESET        32'h00000000
`endif

// *** logic/event_channel_router.v ***
/*
 event channel router: soft event injection, user to channel routing,
 per channel pending and ready status, event detect and overrun flags
 with enables and one interrupt output.
 assumes generators and users are synchronous to clk_i and a simple
 register port with read data one cycle after the read strobe.
*/
// Our own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "evrouter_consts.vh"
module event_channel_router #(
   parameter NCH = `NUM_CHANNELS,
   parameter NUS = `NUM_USERS
) (
   input  wire        clk_i,
   input  wire        arst_n_i,
   input  wire        ce_i,
   input  wire [7:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   input  wire [NCH-1:0] gen_event_i,
   input  wire [NUS-1:0] user_ready_i,
   input  wire [NUS-1:0] user_ack_i,
   output reg  [31:0] rdata_o,
   output reg  [NUS-1:0] user_event_o,
   output reg         irq_o
);

   // ************************************************************
   // registers
   // ************************************************************
   reg  [7:0]     chan_sel_r;
   reg  [7:0]     user_sel_r;
   reg  [1:0]     path_r     [0:NCH-1];
   reg  [7:0]     user_chan_r[0:NUS-1];
   reg  [NCH-1:0] pending_r;
   reg  [NCH-1:0] evd_flag_r;
   reg  [NCH-1:0] ovr_flag_r;
   reg  [NCH-1:0] evd_en_r;
   reg  [NCH-1:0] ovr_en_r;
   reg  [NUS-1:0] wait_r;

   // ************************************************************
   // helpers
   // ************************************************************
   // true when user u is routed to channel c
   function is_routed;
      input [7:0] code;
      input integer c;
      begin
         is_routed = (code != 8'h00) && (code < `CHAN_CODE_LIMIT) &&
                     ({24'h000000, code} == c + 1);
      end
   endfunction

   wire wr_setup = wr_i && (addr_i == `OFS_CHANNEL_SETUP);
   wire wr_route = wr_i && (addr_i == `OFS_USER_ROUTE);
   wire wr_enclr = wr_i && (addr_i == `OFS_IRQ_EN_CLR);
   wire wr_enset = wr_i && (addr_i == `OFS_IRQ_EN_SET);
   wire wr_flag  = wr_i && (addr_i == `OFS_IRQ_FLAG);
   // reserved channel codes are ignored
   wire sel_ok   = wdata_i[7:0] < `CHAN_SEL_LIMIT;
   wire usr_ok   = wdata_i[7:0] < `USER_SEL_LIMIT;

   // path in force this cycle: a path written with a soft event
   // must already govern that event, else an async channel flags
   reg  [NCH-1:0] async_now;
   integer        p;
   always @* begin
      for (p = 0; p < NCH; p = p + 1)
         async_now[p] = (path_r[p] == `PATH_ASYNC);
      if (wr_setup && sel_ok)
         async_now[wdata_i[2:0]] =
            (wdata_i[`PATH_LSB+1:`PATH_LSB] == `PATH_ASYNC);
   end

   // ************************************************************
   // event fan out and status
   // ************************************************************
   reg [NCH-1:0] fire;
   reg [NCH-1:0] ovr_ev;
   reg [NCH-1:0] busy;
   reg [NCH-1:0] ready;
   reg [NUS-1:0] wait_nxt;
   reg [NUS-1:0] deliver;
   integer c;
   integer u;
   always @* begin
      fire     = gen_event_i;
      ovr_ev   = {NCH{1'b0}};
      busy     = {NCH{1'b0}};
      ready    = {NCH{1'b1}};
      deliver  = {NUS{1'b0}};
      wait_nxt = wait_r & ~user_ack_i;
      // soft event written with its channel in one access
      if (wr_setup && wdata_i[`SOFT_EVT_BIT] && sel_ok)
         fire = fire | ({{(NCH-1){1'b0}}, 1'b1} << wdata_i[2:0]);
      for (c = 0; c < NCH; c = c + 1) begin
         for (u = 0; u < NUS; u = u + 1) begin
            if (is_routed(user_chan_r[u], c)) begin
               if (!user_ready_i[u])
                  ready[c] = 1'b0;
               if (wait_r[u])
                  busy[c] = 1'b1;
               if (fire[c]) begin
                  deliver[u]  = 1'b1;
                  wait_nxt[u] = 1'b1;
                  // new event while the old one still waits
                  if (wait_r[u] && !user_ack_i[u])
                     ovr_ev[c] = 1'b1;
               end
            end
         end
      end
   end

   // ************************************************************
   // clocked state
   // ************************************************************
   integer k;
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chan_sel_r   <= 8'h00;
         user_sel_r   <= 8'h00;
         pending_r    <= {NCH{1'b0}};
         evd_flag_r   <= {NCH{1'b0}};
         ovr_flag_r   <= {NCH{1'b0}};
         evd_en_r     <= {NCH{1'b0}};
         ovr_en_r     <= {NCH{1'b0}};
         wait_r       <= {NUS{1'b0}};
         user_event_o <= {NUS{1'b0}};
         irq_o        <= 1'b0;
         rdata_o      <= 32'h00000000;
         for (k = 0; k < NCH; k = k + 1)
            path_r[k] <= `PATH_SYNC;
         for (k = 0; k < NUS; k = k + 1)
            user_chan_r[k] <= 8'h00;
      end else if (ce_i) begin
         wait_r       <= wait_nxt;
         user_event_o <= deliver;
         pending_r    <= busy;
         if (wr_setup && sel_ok) begin
            chan_sel_r <= wdata_i[7:0];
            path_r[wdata_i[2:0]] <= wdata_i[`PATH_LSB+1:`PATH_LSB];
         end
         if (wr_route && usr_ok) begin
            user_sel_r <= wdata_i[7:0];
            user_chan_r[wdata_i[3:0]] <= wdata_i[15:8];
         end
         // enable clear then set
         if (wr_enclr) begin
            evd_en_r <= evd_en_r & ~wdata_i[15:8];
            ovr_en_r <= ovr_en_r & ~wdata_i[7:0];
         end
         if (wr_enset) begin
            evd_en_r <= evd_en_r | wdata_i[15:8];
            ovr_en_r <= ovr_en_r | wdata_i[7:0];
         end
         for (k = 0; k < NCH; k = k + 1) begin
            // set beats a same-cycle clear
            if (fire[k] && !async_now[k])
               evd_flag_r[k] <= 1'b1;
            else if (wr_flag && wdata_i[8+k])
               evd_flag_r[k] <= 1'b0;
            if (ovr_ev[k] && !async_now[k])
               ovr_flag_r[k] <= 1'b1;
            else if (wr_flag && wdata_i[k])
               ovr_flag_r[k] <= 1'b0;
         end
         irq_o <= |((evd_flag_r & evd_en_r) | (ovr_flag_r & ovr_en_r));
         rdata_o <= 32'h00000000;
         if (rd_i) begin
            case (addr_i)
               `OFS_CHANNEL_SETUP:
                  rdata_o <= {6'h00, path_r[chan_sel_r[2:0]],
                              16'h0000, chan_sel_r};
               `OFS_USER_ROUTE:
                  rdata_o <= {16'h0000, user_chan_r[user_sel_r[3:0]],
                              user_sel_r};
               `OFS_CHANNEL_STATE:
                  rdata_o <= {16'h0000, pending_r, ready};
               `OFS_IRQ_EN_CLR,
               `OFS_IRQ_EN_SET:
                  rdata_o <= {16'h0000, evd_en_r, ovr_en_r};
               `OFS_IRQ_FLAG:
                  rdata_o <= {16'h0000, evd_flag_r, ovr_flag_r};
               default:
                  rdata_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** bench/event_channel_router_properties.sv ***
/* port checker for the event channel router.
 assumes the bind below and ce_i held high. */
`timescale 1ns/100ps
`default_nettype none
`include "evrouter_consts.vh"
module event_channel_router_properties #(parameter NCH = 8, NUS = 14) (
   input wire logic           clk_i,
   input wire logic           arst_n_i,
   input wire logic           ce_i,
   input wire logic [7:0]     addr_i,
   input wire logic [31:0]    wdata_i,
   input wire logic           wr_i,
   input wire logic           rd_i,
   input wire logic [NCH-1:0] gen_event_i,
   input wire logic [NUS-1:0] user_ready_i,
   input wire logic [NUS-1:0] user_ack_i,
   input wire logic [31:0]    rdata_o,
   input wire logic [NUS-1:0] user_event_o,
   input wire logic           irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   read_slot_only_a:
      assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside its slot");
   soft_bit_zero_a:
      assert property (rd_i && addr_i == `OFS_CHANNEL_SETUP
      |=> !rdata_o[`SOFT_EVT_BIT]) else $error("soft event bit read one");
   enable_set_a:
      assert property (wr_i && addr_i == `OFS_IRQ_EN_SET ##1 rd_i &&
      addr_i == `OFS_IRQ_EN_CLR |=> (rdata_o & $past(wdata_i, 2)) ==
      ($past(wdata_i, 2) & 32'hffff)) else $error("enable not set");
   enable_clear_a:
      assert property (wr_i && addr_i == `OFS_IRQ_EN_CLR ##1 rd_i &&
      addr_i == `OFS_IRQ_EN_SET |=> (rdata_o & $past(wdata_i, 2)) == 0)
      else $error("enable not cleared");
   irq_masked_a:
      assert property (wr_i && addr_i == `OFS_IRQ_EN_CLR &&
      wdata_i[15:0] == 16'hffff |=> ##1 !irq_o) else $error("irq unmasked");
   irq_needs_en_a:
      assert property (rd_i && addr_i == `OFS_IRQ_EN_SET ##1
      rdata_o[15:0] == 16'h0 |-> !irq_o) else $error("irq without enable");
   route_readback_a:
      assert property (wr_i && ce_i && addr_i == `OFS_USER_ROUTE &&
      wdata_i[7:0] <
      8'h0e && wdata_i[15:8] < 8'h09 ##1 rd_i && addr_i == `OFS_USER_ROUTE
      |=> rdata_o[15:0] == $past(wdata_i[15:0], 2))
      else $error("route read back wrong");
   flag_clear_a:
      assert property (wr_i && addr_i == `OFS_IRQ_FLAG && !gen_event_i ##1
      rd_i && addr_i == `OFS_IRQ_FLAG && !gen_event_i
      |=> (rdata_o & $past(wdata_i, 2)) == 0) else $error("flag not cleared");
endmodule
bind event_channel_router event_channel_router_properties #(.NCH(NCH),
   .NUS(NUS)) event_channel_router_properties_inst (.clk_i(clk_i),
   .arst_n_i(arst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .gen_event_i(gen_event_i),
   .user_ready_i(user_ready_i), .user_ack_i(user_ack_i),
   .rdata_o(rdata_o), .user_event_o(user_event_o), .irq_o(irq_o));
`default_nettype wire

// *** bench/event_user_model.sv ***
/* event users: each drops ready on an event, acks DLY cycles later.
 assumes one clock shared with the router. */
`timescale 1ns/100ps
`default_nettype none
module event_user_model #(parameter NUS = 14, DLY = 6) (
   input  wire logic           clk_i,
   input  wire logic           arst_n_i,
   input  wire logic [NUS-1:0] ev_i,
   output var  logic [NUS-1:0] rdy_o,
   output var  logic [NUS-1:0] ack_o
);
   int cnt [NUS];
   // a new event restarts the wait; the older one is acked only if the new one arrives with cnt at 1
   always @(posedge clk_i or negedge arst_n_i) begin
      for (int u = 0; u < NUS; u++) begin
         if (!arst_n_i) begin
            cnt[u] = 0;
            rdy_o[u] <= 1'h1;
            ack_o[u] <= 1'h0;
         end else begin
            ack_o[u] <= (cnt[u] == 1);
            rdy_o[u] <= !ev_i[u] && cnt[u] < 2;
            if (ev_i[u]) cnt[u] = DLY;
            else if (cnt[u] > 0) cnt[u]--;
         end
      end
   end
endmodule
`default_nettype wire

// *** bench/event_channel_router_tb.sv ***
/* testbench for the event channel router and its users model.
 assumes the consts header on the include path. */
`timescale 1ns/100ps
`default_nettype none
`include "evrouter_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected at %0t: got %h", $time, g); end end
module event_channel_router_tb;
   logic clk_i = 1'h0, arst_n_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
   logic ce_i = 1'h1;
   logic [7:0]  addr_i = 8'h0, gen_event_i = 8'h0;
   logic [31:0] wdata_i = 32'h0;
   wire  [31:0] rdata_o;
   wire  [13:0] user_event_o, user_ready_i, user_ack_i;
   wire         irq_o;
   int          num_errors = 0, tests_run = 0, cyc = 0;
   always #50 clk_i = ~clk_i;
   event_channel_router event_channel_router_inst (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .gen_event_i(gen_event_i),
      .user_ready_i(user_ready_i), .user_ack_i(user_ack_i),
      .rdata_o(rdata_o), .user_event_o(user_event_o), .irq_o(irq_o));
   event_user_model event_user_model_inst (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .ev_i(user_event_o), .rdy_o(user_ready_i),
      .ack_o(user_ack_i));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {wr_i, addr_i, wdata_i} <= {1'h1, a, d};
      @(posedge clk_i);
      wr_i <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffffffff);
      {rd_i, addr_i} <= {1'h1, a};
      @(posedge clk_i);
      rd_i <= 1'h0;
      @(negedge clk_i);
      `CHK(rdata_o & m, e)
      @(posedge clk_i);
   endtask
   task automatic ev(input logic [7:0] m);
      gen_event_i <= m;
      @(posedge clk_i);
      gen_event_i <= 8'h0;
      @(posedge clk_i);
   endtask
   task end_sim;
      if (num_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         end_sim;
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      arst_n_i <= 1'h1;
      @(posedge clk_i);
      rd(`OFS_IRQ_EN_SET, 32'h0);
      rd(`OFS_CHANNEL_STATE, 32'h00ff, 32'hffff);
      wr(`OFS_USER_ROUTE, 32'h0402);
      rd(`OFS_USER_ROUTE, 32'h0402, 32'hffff);
      ce_i <= 1'h0;
      wr(`OFS_USER_ROUTE, 32'h0305);
      ce_i <= 1'h1;
      rd(`OFS_USER_ROUTE, 32'h0402, 32'hffff);
      wr(`OFS_USER_ROUTE, 32'h050e);
      rd(`OFS_USER_ROUTE, 32'h0402, 32'hffff);
      wr(`OFS_IRQ_EN_SET, 32'h0808);
      rd(`OFS_IRQ_EN_CLR, 32'h0808);
      wr(`OFS_CHANNEL_SETUP, 32'h0103);
      rd(`OFS_IRQ_FLAG, 32'h0800);
      rd(`OFS_CHANNEL_STATE, 32'h08f7, 32'hffff);
      ev(8'h08);
      rd(`OFS_IRQ_FLAG, 32'h0808);
      @(negedge clk_i);
      `CHK(irq_o, 1'h1)
      @(posedge clk_i);
      repeat (12) @(posedge clk_i);
      rd(`OFS_CHANNEL_STATE, 32'h00ff, 32'hffff);
      wr(`OFS_IRQ_FLAG, 32'h0800);
      rd(`OFS_IRQ_FLAG, 32'h0008);
      wr(`OFS_IRQ_FLAG, 32'h0008);
      rd(`OFS_IRQ_FLAG, 32'h0);
      @(negedge clk_i);
      `CHK(irq_o, 1'h0)
      @(posedge clk_i);
      wr(`OFS_CHANNEL_SETUP, 32'h0108);
      rd(`OFS_IRQ_FLAG, 32'h0);
      wr(`OFS_CHANNEL_SETUP, 32'h02000103);
      rd(`OFS_IRQ_FLAG, 32'h0);
      rd(`OFS_CHANNEL_SETUP, 32'h02000003);
      ev(8'h08);
      rd(`OFS_IRQ_FLAG, 32'h0);
      wr(`OFS_IRQ_EN_CLR, 32'hffff);
      rd(`OFS_IRQ_EN_SET, 32'h0);
      rd(8'h3c, 32'h0);
      end_sim;
   end
endmodule
`default_nettype wire
